// file: cic_defines.svh
// Constants for the contact input/output conditioning block
//
// Summary of operation
// - Board type code: 0 no board, 1 mixed board, 2 supervision board.
// - Mixed board: sixteen inputs; supervision board: eight plus supervision.
// - Every populated board drives eight outputs, numbered one to eight.
// - Inputs form groups A and B, each sharing one debounce time.
// - Changes shorter than the group debounce, 1 to 50 ms, are ignored.
// - Each input has its own delay, 0 to 60000 ms; zero means none.
// - Level inputs change after debounce time plus input delay time.
// - Positive and negative modes follow the filtered level after the delay.
// - Edge modes fire on a debounced change and skip the input delay.
// - An edge signal clears itself after exactly one logic scan cycle.
// - Positive output follows command, negative inverts; default positive.
// - Pulse output lasts its own pulse time, 0 to 60000 ms, default 10000.
// - Each output reports its physical contact activation.
// - The board reports a status flag for an anomaly or an absent board.
// - After reset debounce is 15 ms and every input is positive level.
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH

`define CIC_NUM_INPUTS 16
`define CIC_NUM_OUTPUTS 8
`define CIC_GROUP_SIZE 8

`define CIC_MS_NS 1000000
`define CIC_CLK_NS 4
`define CIC_MS_TICK_CYCLES ((`CIC_MS_NS + `CIC_CLK_NS - 1) / `CIC_CLK_NS)

`define CIC_DEB_MIN 6'h01
`define CIC_DEB_MAX 6'h32
`define CIC_DEB_DEFAULT 6'h0F
`define CIC_TIME_MAX 16'hEA60
`define CIC_DELAY_DEFAULT 16'h0000
`define CIC_PULSE_DEFAULT 16'h2710

`endif

// file: cic_pkg.sv
// Types for the contact input/output conditioning block
package cic_pkg;
    typedef enum logic [1:0] {
        CIC_BOARD_NONE,
        CIC_BOARD_MIXED,
        CIC_BOARD_SUPERVISION_OPTION
    } cic_board_t;

    typedef enum logic [1:0] {
        CIC_IN_POS,
        CIC_IN_NEG,
        CIC_IN_POS_EDGE,
        CIC_IN_NEG_EDGE
    } cic_in_mode_t;

    typedef enum logic [1:0] {
        CIC_OUT_NORMAL,
        CIC_OUT_PULSE,
        CIC_OUT_LATCH
    } cic_out_type_t;
endpackage : cic_pkg

// file: cic_chan_if.sv
// Interface between the top level and one input conditioning channel
`timescale 1ns/10ps
interface cic_chan_if;
    logic en;
    logic raw;
    logic tick;
    logic scan;
    logic [5:0] deb;
    logic [15:0] delay;
    cic_pkg::cic_in_mode_t mode;
    logic result;

    modport ctrl (output en, raw, tick, scan, deb, delay, mode, input result);
    modport chan (input en, raw, tick, scan, deb, delay, mode, output result);
endinterface : cic_chan_if

// file: cic_input_chan.sv
// One contact input channel: debounce, delay and mode logic
`timescale 1ns/10ps
`include "cic_defines.svh"
module cic_input_chan (
    input wire logic clk,
    input wire logic reset,
    cic_chan_if.chan ch
);
    logic stable_reg, stable_next;
    logic [5:0] deb_cnt_reg, deb_cnt_next;
    logic level_reg, level_next;
    logic [15:0] dly_cnt_reg, dly_cnt_next;
    logic prev_reg, prev_next;
    logic pend_reg, pend_next;
    logic edge_reg, edge_next;
    logic result_reg, result_next;
    logic hit;

    always_comb begin
        stable_next = stable_reg;
        deb_cnt_next = deb_cnt_reg;
        level_next = level_reg;
        dly_cnt_next = dly_cnt_reg;
        // A change must survive the whole window or it is forgotten
        if (ch.raw == stable_reg) begin
            deb_cnt_next = 6'h00;
        end else if (ch.tick) begin
            if (6'(deb_cnt_reg + 6'h01) >= ch.deb) begin
                stable_next = ch.raw;
                deb_cnt_next = 6'h00;
            end else begin
                deb_cnt_next = 6'(deb_cnt_reg + 6'h01);
            end
        end
        // Delay starts only once debounce has settled, so the two add
        if (stable_reg == level_reg) begin
            dly_cnt_next = 16'h0000;
        end else if (dly_cnt_reg >= ch.delay) begin
            level_next = stable_reg;
            dly_cnt_next = 16'h0000;
        end else if (ch.tick) begin
            dly_cnt_next = 16'(dly_cnt_reg + 16'h0001);
        end
        prev_next = stable_reg;
        unique case (ch.mode)
            cic_pkg::CIC_IN_POS_EDGE: hit = stable_reg & ~prev_reg;
            cic_pkg::CIC_IN_NEG_EDGE: hit = ~stable_reg & prev_reg;
            default: hit = 1'b0;
        endcase
        // Edges are shown from one scan tick to the next
        pend_next = pend_reg | hit;
        edge_next = edge_reg;
        if (ch.scan) begin
            edge_next = pend_reg | hit;
            pend_next = 1'b0;
        end
        unique case (ch.mode)
            cic_pkg::CIC_IN_POS: result_next = level_reg;
            cic_pkg::CIC_IN_NEG: result_next = ~level_reg;
            cic_pkg::CIC_IN_POS_EDGE: result_next = edge_reg;
            cic_pkg::CIC_IN_NEG_EDGE: result_next = edge_reg;
        endcase
        if (!ch.en) begin
            result_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stable_reg <= 1'b0;
            deb_cnt_reg <= 6'h00;
            level_reg <= 1'b0;
            dly_cnt_reg <= 16'h0000;
            prev_reg <= 1'b0;
            pend_reg <= 1'b0;
            edge_reg <= 1'b0;
            result_reg <= 1'b0;
        end else begin
            stable_reg <= stable_next;
            deb_cnt_reg <= deb_cnt_next;
            level_reg <= level_next;
            dly_cnt_reg <= dly_cnt_next;
            prev_reg <= prev_next;
            pend_reg <= pend_next;
            edge_reg <= edge_next;
            result_reg <= result_next;
        end
    end

    assign ch.result = result_reg;

    a_deb_on_tick: assert property (@(posedge clk) disable iff (reset)
        $changed(stable_reg) |-> $past(ch.tick))
        else $error("Debounced level moved without a millisecond tick");
    a_delay_zero_pass: assert property (@(posedge clk)
        disable iff (reset)
        (ch.delay == 16'h0000 && stable_reg != level_reg)
        |=> level_reg == $past(stable_reg))
        else $error("Zero delay did not pass the level at once");
    a_edge_scan_clear: assert property (@(posedge clk)
        disable iff (reset)
        (ch.scan && !pend_reg && !hit) ##1
        (ch.en && ch.mode == cic_pkg::CIC_IN_POS_EDGE) |=> !result_reg)
        else $error("Edge signal held past one scan cycle");
    a_neg_level_inv: assert property (@(posedge clk)
        disable iff (reset)
        (ch.en && ch.mode == cic_pkg::CIC_IN_NEG)
        |=> result_reg == !$past(level_reg))
        else $error("Negative level mode not inverted");
endmodule : cic_input_chan

// file: cic_contact_io.sv
// Contact input/output conditioning for one plug-in I/O board
`timescale 1ns/10ps
`include "cic_defines.svh"
module cic_contact_io #(
    parameter int TICK_CYCLES = `CIC_MS_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    // Settings, captured on config_write
    input wire logic config_write,
    input wire logic [1:0] board_type,
    input wire logic [5:0] debounce_a,
    input wire logic [5:0] debounce_b,
    input wire logic [31:0] input_type,
    input wire logic [255:0] input_delay,
    input wire logic [7:0] output_negative,
    input wire logic [15:0] output_type,
    input wire logic [127:0] pulse_time,
    // Live signals
    input wire logic board_fault,
    input wire logic scan_tick,
    input wire logic [15:0] contact_inputs_raw,
    input wire logic [7:0] output_operate_command,
    input wire logic [7:0] output_latch_reset,
    output logic [15:0] contact_input_state,
    output logic [7:0] contact_output_drive,
    output logic [7:0] contact_output_state,
    output logic board_status
);
    localparam int NI = `CIC_NUM_INPUTS;
    localparam int NO = `CIC_NUM_OUTPUTS;

    // ------------------------------------------------------------
    // Setting clamps
    // ------------------------------------------------------------
    function automatic logic [15:0] clamp_time(input logic [15:0] t);
        clamp_time = (t > `CIC_TIME_MAX) ? `CIC_TIME_MAX : t;
    endfunction : clamp_time

    function automatic logic [5:0] clamp_deb(input logic [5:0] d);
        if (d < `CIC_DEB_MIN) begin
            clamp_deb = `CIC_DEB_MIN;
        end else if (d > `CIC_DEB_MAX) begin
            clamp_deb = `CIC_DEB_MAX;
        end else begin
            clamp_deb = d;
        end
    endfunction : clamp_deb

    // ------------------------------------------------------------
    // Setting registers
    // ------------------------------------------------------------
    cic_pkg::cic_board_t board_reg, board_next;
    logic [5:0] deb_a_reg, deb_a_next;
    logic [5:0] deb_b_reg, deb_b_next;
    cic_pkg::cic_in_mode_t mode_reg [NI], mode_next [NI];
    logic [15:0] delay_reg [NI], delay_next [NI];
    logic [7:0] neg_reg, neg_next;
    cic_pkg::cic_out_type_t otype_reg [NO], otype_next [NO];
    logic [15:0] pulse_reg [NO], pulse_next [NO];
    logic bad_type_reg, bad_type_next;

    always_comb begin
        board_next = board_reg;
        deb_a_next = deb_a_reg;
        deb_b_next = deb_b_reg;
        neg_next = neg_reg;
        bad_type_next = bad_type_reg;
        mode_next = mode_reg;
        delay_next = delay_reg;
        otype_next = otype_reg;
        pulse_next = pulse_reg;
        if (config_write) begin
            // Code 3 selects no board and is flagged as an anomaly
            bad_type_next = (board_type == 2'h3);
            board_next = bad_type_next ? cic_pkg::CIC_BOARD_NONE
                : cic_pkg::cic_board_t'(board_type);
            deb_a_next = clamp_deb(debounce_a);
            deb_b_next = clamp_deb(debounce_b);
            neg_next = output_negative;
            for (int i = 0; i < NI; i++) begin
                mode_next[i] = cic_pkg::cic_in_mode_t'(input_type[2*i +: 2]);
                delay_next[i] = clamp_time(input_delay[16*i +: 16]);
            end
            for (int j = 0; j < NO; j++) begin
                // Unused type code falls back to normal
                otype_next[j] = (output_type[2*j +: 2] == 2'h3)
                    ? cic_pkg::CIC_OUT_NORMAL
                    : cic_pkg::cic_out_type_t'(output_type[2*j +: 2]);
                pulse_next[j] = clamp_time(pulse_time[16*j +: 16]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            board_reg <= cic_pkg::CIC_BOARD_NONE;
            deb_a_reg <= `CIC_DEB_DEFAULT;
            deb_b_reg <= `CIC_DEB_DEFAULT;
            neg_reg <= 8'h00;
            bad_type_reg <= 1'b0;
            for (int i = 0; i < NI; i++) begin
                mode_reg[i] <= cic_pkg::CIC_IN_POS;
                delay_reg[i] <= `CIC_DELAY_DEFAULT;
            end
            for (int j = 0; j < NO; j++) begin
                otype_reg[j] <= cic_pkg::CIC_OUT_NORMAL;
                pulse_reg[j] <= `CIC_PULSE_DEFAULT;
            end
        end else begin
            board_reg <= board_next;
            deb_a_reg <= deb_a_next;
            deb_b_reg <= deb_b_next;
            neg_reg <= neg_next;
            bad_type_reg <= bad_type_next;
            mode_reg <= mode_next;
            delay_reg <= delay_next;
            otype_reg <= otype_next;
            pulse_reg <= pulse_next;
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [17:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;

    always_comb begin
        tick_next = (tick_cnt_reg == 18'(TICK_CYCLES - 1));
        tick_cnt_next = tick_next ? 18'h00000 : 18'(tick_cnt_reg + 18'h00001);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tick_cnt_reg <= 18'h00000;
            tick_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // Input channels
    // ------------------------------------------------------------
    logic present;
    logic [15:0] in_state;
    assign present = (board_reg != cic_pkg::CIC_BOARD_NONE);

    // On a supervision board the upper eight carry supervision signals,
    // conditioned exactly like the general inputs
    generate
        for (genvar g = 0; g < NI; g++) begin : g_in
            cic_chan_if ch ();
            assign ch.en = present;
            assign ch.raw = contact_inputs_raw[g];
            assign ch.tick = tick_reg;
            assign ch.scan = scan_tick;
            assign ch.deb = (g < `CIC_GROUP_SIZE)
                ? deb_a_reg : deb_b_reg;
            assign ch.delay = delay_reg[g];
            assign ch.mode = mode_reg[g];
            assign in_state[g] = ch.result;
            cic_input_chan u_chan (
                .clk(clk),
                .reset(reset),
                .ch(ch)
            );
        end
    endgenerate

    assign contact_input_state = in_state;

    // ------------------------------------------------------------
    // Output channels
    // ------------------------------------------------------------
    logic [7:0] act_reg, act_next;
    logic [7:0] latch_reg, latch_next;
    logic [7:0] cmd_prev_reg, cmd_prev_next;
    logic [15:0] ptimer_reg [NO], ptimer_next [NO];
    logic [7:0] drive_reg, drive_next;
    logic status_reg, status_next;

    always_comb begin
        act_next = 8'h00;
        latch_next = latch_reg;
        ptimer_next = ptimer_reg;
        cmd_prev_next = output_operate_command;
        for (int j = 0; j < NO; j++) begin
            // Set wins when operate and reset arrive together
            if (output_operate_command[j]) begin
                latch_next[j] = 1'b1;
            end else if (output_latch_reset[j]) begin
                latch_next[j] = 1'b0;
            end
            // Pulse starts on the rising command and ignores its length
            if (output_operate_command[j] && !cmd_prev_reg[j]) begin
                ptimer_next[j] = pulse_reg[j];
            end else if (tick_reg && ptimer_reg[j] != 16'h0000) begin
                ptimer_next[j] = 16'(ptimer_reg[j] - 16'h0001);
            end
            unique case (otype_reg[j])
                cic_pkg::CIC_OUT_NORMAL: begin
                    act_next[j] = output_operate_command[j];
                end
                cic_pkg::CIC_OUT_LATCH: act_next[j] = latch_next[j];
                cic_pkg::CIC_OUT_PULSE: begin
                    act_next[j] = (ptimer_next[j] != 16'h0000);
                end
            endcase
            if (otype_reg[j] != cic_pkg::CIC_OUT_LATCH) begin
                latch_next[j] = 1'b0;
            end
            if (!present) begin
                act_next[j] = 1'b0;
            end
        end
        drive_next = present ? (act_next ^ neg_reg) : 8'h00;
        status_next = !present || bad_type_reg || board_fault;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            act_reg <= 8'h00;
            latch_reg <= 8'h00;
            cmd_prev_reg <= 8'h00;
            drive_reg <= 8'h00;
            status_reg <= 1'b1;
            for (int j = 0; j < NO; j++) begin
                ptimer_reg[j] <= 16'h0000;
            end
        end else begin
            act_reg <= act_next;
            latch_reg <= latch_next;
            cmd_prev_reg <= cmd_prev_next;
            drive_reg <= drive_next;
            status_reg <= status_next;
            ptimer_reg <= ptimer_next;
        end
    end

    assign contact_output_drive = drive_reg;
    assign contact_output_state = drive_reg;
    assign board_status = status_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_latch_set(int k);
        output_operate_command[k] && otype_reg[k] == cic_pkg::CIC_OUT_LATCH
        && present;
    endsequence

    sequence s_no_reset(int k);
        !output_latch_reset[k] && !output_operate_command[k]
        && otype_reg[k] == cic_pkg::CIC_OUT_LATCH && !config_write && present;
    endsequence

    sequence s_latch_clear(int k);
        output_latch_reset[k] && !output_operate_command[k]
        && otype_reg[k] == cic_pkg::CIC_OUT_LATCH && present;
    endsequence

    a_tick_single: assert property (@(posedge clk) disable iff (reset)
        tick_reg |=> !tick_reg)
        else $error("Millisecond tick lasted more than one cycle");
    a_latch_hold: assert property (@(posedge clk) disable iff (reset)
        s_latch_set(2) ##1 s_no_reset(2) [*3] |=> act_reg[2])
        else $error("Latched output dropped without reset");
    a_latch_clear: assert property (@(posedge clk) disable iff (reset)
        s_latch_clear(2) |=> !act_reg[2])
        else $error("Latched output survived its reset");
    a_normal_follow: assert property (@(posedge clk) disable iff (reset)
        (present && otype_reg[2] == cic_pkg::CIC_OUT_NORMAL)
        |=> act_reg[2] == $past(output_operate_command[2]))
        else $error("Normal output did not follow the command");
    a_polarity_map: assert property (@(posedge clk) disable iff (reset)
        present ##1 present |-> drive_reg == (act_reg ^ $past(neg_reg)))
        else $error("Drive does not match activation and polarity");
    a_absent_quiet: assert property (@(posedge clk) disable iff (reset)
        !present |=> drive_reg == 8'h00 && status_reg)
        else $error("Absent board drove outputs or hid its status");
    a_in_absent: assert property (@(posedge clk) disable iff (reset)
        !present |=> contact_input_state == 16'h0000)
        else $error("Absent board showed an active input");
    a_board_code: assert property (@(posedge clk) disable iff (reset)
        (config_write && board_type == 2'h2)
        |=> board_reg == cic_pkg::CIC_BOARD_SUPERVISION_OPTION)
        else $error("Supervision board code not taken");
    a_pulse_zero: assert property (@(posedge clk) disable iff (reset)
        (present && otype_reg[3] == cic_pkg::CIC_OUT_PULSE
         && pulse_reg[3] == 16'h0000 && ptimer_reg[3] == 16'h0000)
        |=> !act_reg[3])
        else $error("Zero pulse length produced a pulse");
    a_pulse_start: assert property (@(posedge clk) disable iff (reset)
        (present && otype_reg[3] == cic_pkg::CIC_OUT_PULSE
         && pulse_reg[3] > 16'h0002 && !config_write
         && output_operate_command[3] && !cmd_prev_reg[3])
        |=> act_reg[3] ##1 act_reg[3])
        else $error("Pulse output did not start");
    a_deb_default: assert property (@(posedge clk)
        $fell(reset) |-> deb_a_reg == `CIC_DEB_DEFAULT
        && deb_b_reg == `CIC_DEB_DEFAULT)
        else $error("Debounce did not reset to its default");
    a_out_defaults: assert property (@(posedge clk)
        $fell(reset) |-> neg_reg == 8'h00
        && otype_reg[0] == cic_pkg::CIC_OUT_NORMAL)
        else $error("Output settings did not reset to defaults");
endmodule : cic_contact_io

// file: cic_master_model.sv
// Model of the master logic: scan boundary and per-output commands
`timescale 1ns/10ps
module cic_master_model #(
    parameter int SCAN_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset,
    output logic scan_tick,
    output logic [7:0] output_operate_command,
    output logic [7:0] output_latch_reset
);
    int scan_cnt = 0;
    initial begin
        scan_tick = 1'b0;
        output_operate_command = 8'h00;
        output_latch_reset = 8'h00;
    end
    // One-cycle scan pulse, moved off the sampling edge
    always @(negedge clk) begin
        scan_cnt <= (reset || scan_cnt == SCAN_CYCLES - 1) ? 0
            : scan_cnt + 1;
        scan_tick <= !reset && scan_cnt == SCAN_CYCLES - 1;
    end
    task automatic send(input logic [7:0] operate, input logic [7:0] clear);
        @(negedge clk);
        output_operate_command = operate;
        output_latch_reset = clear;
    endtask : send
endmodule : cic_master_model

// file: cic_contact_io_tb_top.sv
// Self-checking testbench of the contact input/output conditioning block
`timescale 1ns/10ps
module cic_contact_io_tb_top;
    localparam int TICK = 10;
    localparam int SCAN = 20;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic config_write = 1'b0;
    logic [1:0] board_type = 2'h0;
    logic [5:0] debounce_a = 6'h0F;
    logic [5:0] debounce_b = 6'h0F;
    logic [31:0] input_type = 32'h0;
    logic [255:0] input_delay = 256'h0;
    logic [7:0] output_negative = 8'h00;
    logic [15:0] output_type = 16'h0000;
    logic [127:0] pulse_time = {8{16'h2710}};
    logic board_fault = 1'b0;
    logic scan_tick;
    logic [15:0] raw = 16'h0000;
    logic [7:0] operate;
    logic [7:0] clear;
    logic [15:0] in_state;
    logic [7:0] drive;
    logic [7:0] out_state;
    logic board_status;
    int miscompares = 0;
    int tests_run = 0;
    always #2 clk = ~clk;
    cic_contact_io #(.TICK_CYCLES(TICK)) u_cic_contact_io (
        .clk(clk), .reset(reset), .config_write(config_write),
        .board_type(board_type), .debounce_a(debounce_a),
        .debounce_b(debounce_b), .input_type(input_type),
        .input_delay(input_delay), .output_negative(output_negative),
        .output_type(output_type), .pulse_time(pulse_time),
        .board_fault(board_fault), .scan_tick(scan_tick),
        .contact_inputs_raw(raw), .output_operate_command(operate),
        .output_latch_reset(clear), .contact_input_state(in_state),
        .contact_output_drive(drive), .contact_output_state(out_state),
        .board_status(board_status));
    cic_master_model #(.SCAN_CYCLES(SCAN)) u_cic_master_model (
        .clk(clk), .reset(reset), .scan_tick(scan_tick),
        .output_operate_command(operate), .output_latch_reset(clear));
    task automatic check_bit(input string name, input logic exp,
                             input logic got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit
    task automatic check_range(input string name, input int lo, input int hi,
                               input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi,
                     got);
        end
    endtask : check_range
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic cfg();
        step(1);
        config_write = 1'b1;
        step(1);
        config_write = 1'b0;
    endtask : cfg
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_board();
        u_cic_master_model.send(8'hFF, 8'h00);
        step(2);
        check_bit("absent status", 1'b1, board_status);
        check_bit("absent drive", 1'b0, drive[0]);
        u_cic_master_model.send(8'h00, 8'h00);
        for (int code = 0; code < 4; code++) begin
            board_type = code[1:0];
            cfg();
            step(1);
            check_bit("board status", !(code == 1 || code == 2),
                      board_status);
        end
        board_type = 2'h1;
        cfg();
        board_fault = 1'b1;
        step(2);
        check_bit("fault status", 1'b1, board_status);
        board_fault = 1'b0;
        step(2);
        check_bit("healthy status", 1'b0, board_status);
    endtask : t_board
    task automatic t_outputs();
        int w;
        output_negative = 8'h02;
        output_type = 16'h0060;
        pulse_time[15:0] = 16'h0001;
        pulse_time[63:48] = 16'h0003;
        cfg();
        u_cic_master_model.send(8'h05, 8'h01);
        step(1);
        check_bit("normal drive", 1'b1, drive[0]);
        check_bit("normal state", 1'b1, out_state[0]);
        check_bit("negative idle", 1'b1, drive[1]);
        check_bit("latch set", 1'b1, drive[2]);
        u_cic_master_model.send(8'h01, 8'h00);
        step(40);
        check_bit("normal ignores pulse", 1'b1, drive[0]);
        check_bit("latch held", 1'b1, drive[2]);
        u_cic_master_model.send(8'h04, 8'h04);
        step(2);
        check_bit("operate beats reset", 1'b1, drive[2]);
        u_cic_master_model.send(8'h00, 8'h04);
        step(1);
        check_bit("latch cleared", 1'b0, drive[2]);
        check_bit("normal released", 1'b0, drive[0]);
        u_cic_master_model.send(8'h08, 8'h00);
        w = 0;
        step(1);
        while (drive[3] === 1'b1 && w < 100) begin
            step(1);
            w++;
        end
        check_range("pulse width", 2 * TICK, 3 * TICK + 1, w);
        u_cic_master_model.send(8'h00, 8'h00);
        pulse_time[63:48] = 16'h0000;
        cfg();
        u_cic_master_model.send(8'h08, 8'h00);
        step(2);
        check_bit("zero pulse", 1'b0, drive[3]);
        u_cic_master_model.send(8'h00, 8'h00);
    endtask : t_outputs
    task automatic t_levels();
        int t0;
        int t1;
        debounce_a = 6'h02;
        debounce_b = 6'h01;
        input_delay[31:16] = 16'h0003;
        input_type[17:16] = 2'h1;
        cfg();
        step(5);
        check_bit("negative idle input", 1'b1, in_state[8]);
        raw[0] = 1'b1;
        step(8);
        raw[0] = 1'b0;
        step(30);
        check_bit("glitch ignored", 1'b0, in_state[0]);
        raw = 16'h0103;
        t0 = -1;
        t1 = -1;
        for (int c = 1; c < 90; c++) begin
            step(1);
            if (t0 < 0 && in_state[0] === 1'b1) t0 = c;
            if (t1 < 0 && in_state[1] === 1'b1) t1 = c;
        end
        check_range("input latency", TICK, 2 * TICK + 4, t0);
        check_range("delayed latency", 3 * TICK, 5 * TICK + 6, t1);
        check_bit("negative active input", 1'b0, in_state[8]);
    endtask : t_levels
    task automatic edge_pulse(input int idx);
        int t;
        int w;
        t = 0;
        w = 0;
        while (in_state[idx] !== 1'b1 && t < 80) begin
            step(1);
            t++;
        end
        check_range("edge rise", 1, 60, t);
        while (in_state[idx] === 1'b1 && w < 100) begin
            step(1);
            w++;
        end
        check_range("edge width", SCAN, SCAN, w);
    endtask : edge_pulse
    task automatic t_edges();
        raw[3] = 1'b1;
        step(40);
        input_type[7:4] = 4'hE;
        input_delay[47:32] = 16'h0032;
        cfg();
        step(50);
        check_bit("edge idle", 1'b0, in_state[3]);
        raw[2] = 1'b1;
        edge_pulse(2);
        raw[3] = 1'b0;
        edge_pulse(3);
    endtask : t_edges
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        check_bit("reset status", 1'b1, board_status);
        check_bit("reset drive", 1'b0, drive[0]);
        t_board();
        t_outputs();
        t_levels();
        t_edges();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule : cic_contact_io_tb_top
